// >>> core/sarcc_ctrl.sv
// Behaviour
// RULE1: a falling edge on conversion_start_n ends acquisition and starts a conversion.
// RULE2: at conversion start the ground switches open first, and only then are the arrays tied to reference_ground.
// RULE3: the result is found by successive approximation over 16 halving steps, msb first, down to one lsb.
// RULE4: once the approximation ends the output code is formed and busy drops.
// RULE5: each result belongs to the sample taken at the start of the same conversion, with no pipeline delay.
// RULE6: three modes exist, fastest (up to 570 kSPS), normal (up to 500 kSPS) and low-power.
// RULE7: in fastest mode the host should discard the first result after a gap above 1 ms or after power-up.
// RULE8: normal mode gives full accuracy whatever the gap between conversions.
// RULE9: low-power mode cuts power between conversions so power follows the conversion rate.
// RULE10: coding_select high gives straight binary, low gives twos complement.
// RULE11: codes run 0000..ffff in binary and 8000..7fff in twos complement, which is binary with the msb inverted.
// RULE12: overrange gives the top code and underrange the bottom code of the chosen coding.
// RULE13: busy rises when a conversion starts and stays high until the result is latched.
// RULE14: a high reset restarts the block and aborts any conversion.
// RULE15: power_down lets a running conversion finish, then blocks new ones and saves power.
// RULE16: a start edge while busy is ignored.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`include "sarcc_regs.svh"
module sarcc_ctrl
  import sarcc_pkg::*;
#(
  parameter int W = `SARCC_BITS,
  parameter int GAP_CYCLES = `SARCC_GAP_CYC
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic conversion_start_n_i,
  input wire logic coding_select_i,
  input wire logic power_down_i,
  input wire logic comparator_i,
  input wire logic [`SARCC_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  output logic busy_o,
  output sarcc_sw_t switches_o,
  output logic [W-1:0] dac_trial_o,
  output sarcc_result_t result_o,
  output logic result_valid_o,
  output logic low_power_o
);

  localparam int GAP_W = $clog2(GAP_CYCLES + 1);
  localparam int WARP_BUSY = 2 + W * `SARCC_WARP_STEP;
  localparam int NORM_BUSY = 2 + W * `SARCC_NORM_STEP;
  localparam sarcc_sw_t SW_ACQ = '{1'b1, 1'b1, 1'b1, 1'b0};

  function automatic logic [7:0] step_len(input logic [1:0] m);
    // fastest mode trims each step; a reserved code falls back to normal timing [RULE6]
    step_len = (m == SARCC_WARP) ? 8'(`SARCC_WARP_STEP) : 8'(`SARCC_NORM_STEP);
  endfunction

  function automatic logic [W-1:0] form_code(input logic [W-1:0] raw, input logic binary);
    // twos complement is the binary code with the msb turned over [RULE10] [RULE11]
    form_code = binary ? raw : (raw ^ W'(`SARCC_TWOS_FLIP));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: only the second stage feeds logic, except the start pin, whose edge detect also uses a third stage
  logic [2:0] cnv_s_q;
  logic [1:0] sel_s_q, pd_s_q, cmp_s_q;
  logic start_fall;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnv_s_q <= 3'h7;
      sel_s_q <= 2'h3;
      pd_s_q <= 2'h0;
      cmp_s_q <= 2'h0;
    end else begin
      cnv_s_q <= {cnv_s_q[1:0], conversion_start_n_i};
      sel_s_q <= {sel_s_q[0], coding_select_i};
      pd_s_q <= {pd_s_q[0], power_down_i};
      cmp_s_q <= {cmp_s_q[0], comparator_i};
    end
  end

  assign start_fall = cnv_s_q[2] & ~cnv_s_q[1]; // [RULE1]

  ////////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  sarcc_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic busy_d, vld_d, lowp_d;
  sarcc_sw_t sw_d;
  sarcc_result_t res_d;
  logic [1:0] mode_q, mode_d, conv_mode_q, conv_mode_d;
  logic [GAP_W-1:0] gap_q, gap_d;
  logic seen_q, seen_d, stale_q, stale_d;
  logic sar_start, sar_step, sar_last;
  logic [W-1:0] sar_result;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    busy_d = busy_o;
    sw_d = switches_o;
    res_d = result_o;
    vld_d = 1'b0;
    conv_mode_d = conv_mode_q;
    seen_d = seen_q;
    stale_d = stale_q;
    sar_start = 1'b0;
    sar_step = 1'b0;
    // cycles since the previous start, busy or idle, saturating at the gap limit
    gap_d = (gap_q == GAP_W'(GAP_CYCLES)) ? gap_q : gap_q + GAP_W'(1);
    unique case (state_q)
      ST_IDLE: begin
        // power_down is only honoured here, so a running conversion always ends [RULE15]
        if (pd_s_q[1]) begin
          state_d = ST_DOWN;
        end else if (start_fall) begin // [RULE1] [RULE16]
          busy_d = 1'b1; // [RULE13]
          sw_d.array_ground_switch = 1'b0; // [RULE2]
          sw_d.dummy_ground_switch = 1'b0;
          conv_mode_d = mode_q;
          // fastest mode loses accuracy after a long gap; flag it so the host can drop it [RULE7]
          stale_d = (mode_q == SARCC_WARP) && (!seen_q || gap_q == GAP_W'(GAP_CYCLES)); // [RULE8]
          seen_d = 1'b1;
          gap_d = '0;
          state_d = ST_OPEN;
        end
      end
      ST_OPEN: begin
        // ground switches were opened a cycle ago; now swap inputs for reference ground [RULE2]
        sw_d.inputs_connect = 1'b0;
        sw_d.reference_ground = 1'b1;
        sar_start = 1'b1; // [RULE3]
        cnt_d = '0;
        state_d = ST_STEP;
      end
      ST_STEP: begin
        // comparator sampled at the end of each step; two sync cycles fit inside it
        if (cnt_q == step_len(conv_mode_q) - 8'h01) begin
          cnt_d = '0;
          sar_step = 1'b1; // [RULE3]
          if (sar_last) begin
            state_d = ST_LATCH;
          end
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      ST_LATCH: begin
        // code and busy change on the same edge, so busy falling marks valid data [RULE4] [RULE13]
        res_d.code = form_code(sar_result, sel_s_q[1]); // [RULE5] [RULE12]
        res_d.stale = stale_q;
        vld_d = 1'b1;
        busy_d = 1'b0; // [RULE4]
        sw_d = SW_ACQ;
        state_d = ST_IDLE;
      end
      ST_DOWN: begin
        // start edges are not acted on while powered down [RULE15]
        if (!pd_s_q[1]) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    // impulse mode powers down between conversions; the next start wakes it [RULE9]
    lowp_d = (state_d == ST_DOWN) || (state_d == ST_IDLE && mode_q == SARCC_IMPULSE);
  end

  // async reset aborts a conversion and returns the switches to acquisition [RULE14]
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      busy_o <= 1'b0;
      switches_o <= SW_ACQ;
      result_o <= '0;
      result_valid_o <= 1'b0;
      low_power_o <= 1'b0;
      conv_mode_q <= `SARCC_CTRL_RST;
      gap_q <= '0;
      seen_q <= 1'b0;
      stale_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy_o <= busy_d;
      switches_o <= sw_d;
      result_o <= res_d;
      result_valid_o <= vld_d;
      low_power_o <= lowp_d;
      conv_mode_q <= conv_mode_d;
      gap_q <= gap_d;
      seen_q <= seen_d;
      stale_q <= stale_d;
    end
  end

  sarcc_sar #(
    .W(W)
  ) u_sar (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .start_i(sar_start),
    .step_i(sar_step),
    .keep_i(cmp_s_q[1]),
    .trial_o(dac_trial_o),
    .last_o(sar_last),
    .result_o(sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register port: mode is taken at each start, so a write mid-conversion waits
  logic [31:0] rd_d;

  always_comb begin
    mode_d = mode_q;
    rd_d = '0;
    if (wr_i && addr_i == `SARCC_CTRL_OFS) begin
      mode_d = wr_data_i[`SARCC_CTRL_MODE_LSB +: 2]; // [RULE6]
    end
    if (rd_i) begin
      unique case (addr_i)
        `SARCC_CTRL_OFS: rd_d[`SARCC_CTRL_MODE_LSB +: 2] = mode_q;
        `SARCC_STAT_OFS: begin
          rd_d[`SARCC_STAT_BUSY_BIT] = busy_o;
          rd_d[`SARCC_STAT_DOWN_BIT] = (state_q == ST_DOWN);
          rd_d[`SARCC_STAT_STALE_BIT] = result_o.stale;
          rd_d[`SARCC_STAT_LOWP_BIT] = low_power_o;
          rd_d[`SARCC_STAT_MODE_LSB +: 2] = conv_mode_q;
        end
        `SARCC_CODE_OFS: begin
          rd_d[W-1:0] = result_o.code;
          rd_d[`SARCC_CODE_STALE_BIT] = result_o.stale;
        end
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= `SARCC_CTRL_RST;
      rd_data_o <= '0;
    end else begin
      mode_q <= mode_d;
      rd_data_o <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  start_raises_busy_a: assert property ( // [RULE1]
    state_q == ST_IDLE && !pd_s_q[1] && start_fall |=> busy_o && state_q == ST_OPEN)
    else $error("accepted start did not raise busy");

  switches_open_a: assert property ( // [RULE2]
    state_q == ST_OPEN |-> !switches_o.array_ground_switch && !switches_o.dummy_ground_switch
      && switches_o.inputs_connect && !switches_o.reference_ground ##1 switches_o.reference_ground)
    else $error("ground switches not opened before tie to reference ground");

  msb_trial_a: assert property ( // [RULE3]
    sar_start |=> dac_trial_o == {1'b1, {(W-1){1'b0}}})
    else $error("approximation did not start at the msb");

  code_at_busy_a: assert property ( // [RULE4]
    state_q == ST_LATCH |=> $fell(busy_o) && result_valid_o
      && result_o.code == form_code($past(sar_result), $past(sel_s_q[1])))
    else $error("busy fell without the formed code");

  warp_length_a: assert property ( // [RULE6]
    $rose(busy_o) && conv_mode_q == SARCC_WARP |-> ##WARP_BUSY $fell(busy_o))
    else $error("fastest conversion length wrong");

  norm_length_a: assert property ( // [RULE8]
    $rose(busy_o) && conv_mode_q == SARCC_NORMAL |-> ##NORM_BUSY $fell(busy_o))
    else $error("normal conversion length wrong");

  impulse_sleep_a: assert property ( // [RULE9]
    state_q == ST_IDLE && mode_q == SARCC_IMPULSE && $stable(mode_q) && !$fell(busy_o) |-> low_power_o)
    else $error("impulse mode idle without low power");

  awake_busy_a: assert property ( // [RULE9]
    state_q == ST_STEP |-> !low_power_o)
    else $error("low power while converting");

  no_restart_a: assert property ( // [RULE16]
    state_q == ST_STEP |=> state_q == ST_STEP || state_q == ST_LATCH)
    else $error("start edge disturbed a conversion");

  down_holds_a: assert property ( // [RULE15]
    state_q == ST_DOWN && pd_s_q[1] |=> !busy_o && low_power_o)
    else $error("conversion started while powered down");

  warp_done_c: cover property ($fell(busy_o) && conv_mode_q == SARCC_WARP);
  twos_result_c: cover property (result_valid_o && !sel_s_q[1]);
  stale_flag_c: cover property (result_valid_o && result_o.stale);
  powered_down_c: cover property (state_q == ST_DOWN);

endmodule

// >>> core/sarcc_pkg.sv
package sarcc_pkg;

  typedef enum logic [1:0] {
    SARCC_WARP,
    SARCC_NORMAL,
    SARCC_IMPULSE
  } sarcc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPEN,
    ST_STEP,
    ST_LATCH,
    ST_DOWN
  } sarcc_state_t;

  typedef struct packed {
    logic array_ground_switch;
    logic dummy_ground_switch;
    logic inputs_connect;
    logic reference_ground;
  } sarcc_sw_t;

  typedef struct packed {
    logic [15:0] code;
    logic stale;
  } sarcc_result_t;

endpackage

// >>> core/sarcc_regs.svh
`ifndef SARCC_REGS_SVH
`define SARCC_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register map on the plain port, byte addresses
`define SARCC_ADDR_W 4
`define SARCC_CTRL_OFS 4'h0
`define SARCC_STAT_OFS 4'h4
`define SARCC_CODE_OFS 4'h8
`define SARCC_CTRL_MODE_LSB 0
`define SARCC_CTRL_RST 2'h1
`define SARCC_STAT_BUSY_BIT 0
`define SARCC_STAT_DOWN_BIT 1
`define SARCC_STAT_STALE_BIT 2
`define SARCC_STAT_LOWP_BIT 3
`define SARCC_STAT_MODE_LSB 4
`define SARCC_CODE_STALE_BIT 16

////////////////////////////////////////////////////////////////////////////////
// conversion timing
`define SARCC_BITS 16
`define SARCC_TWOS_FLIP 16'h8000
`define SARCC_CLK_KHZ 50000
`define SARCC_WARP_KSPS 570
`define SARCC_NORM_KSPS 500
`define SARCC_SLOTS 20
`define SARCC_WARP_STEP (`SARCC_CLK_KHZ / `SARCC_WARP_KSPS / `SARCC_SLOTS)
`define SARCC_NORM_STEP (`SARCC_CLK_KHZ / `SARCC_NORM_KSPS / `SARCC_SLOTS)
`define SARCC_GAP_US 1000
`define SARCC_GAP_CYC (`SARCC_GAP_US * `SARCC_CLK_KHZ / 1000)

`endif

// >>> core/sarcc_sar.sv
module sarcc_sar
  import sarcc_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic step_i,
  input wire logic keep_i,
  output logic [W-1:0] trial_o,
  output logic last_o,
  output logic [W-1:0] result_o
);

  logic [W-1:0] mask_q, mask_d;
  logic [W-1:0] trial_d, result_d;

  ////////////////////////////////////////////////////////////////////////////////
  // one-hot mask walks from msb down to lsb, halving the weight each step
  always_comb begin
    mask_d = mask_q;
    trial_d = trial_o;
    result_d = result_o;
    if (start_i) begin
      mask_d = {1'b1, {(W-1){1'b0}}}; // [RULE3]
      trial_d = {1'b1, {(W-1){1'b0}}};
    end else if (step_i) begin
      // comparator low means the trial overshot: drop the bit under test [RULE3]
      trial_d = keep_i ? trial_o : (trial_o & ~mask_q);
      mask_d = mask_q >> 1;
      trial_d = trial_d | mask_d;
      if (mask_q[0]) begin
        result_d = keep_i ? trial_o : (trial_o & ~mask_q);
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mask_q <= '0;
      trial_o <= '0;
      result_o <= '0;
    end else begin
      mask_q <= mask_d;
      trial_o <= trial_d;
      result_o <= result_d;
    end
  end

  assign last_o = mask_q[0];

  lsb_last_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE3]
    step_i && mask_q[0] |=> mask_q == '0)
    else $error("mask did not retire after the lsb step");

endmodule

// >>> tb/sarcc_afe_model.sv
module sarcc_afe_model
  import sarcc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input var int vin_i,
  input wire sarcc_sw_t switches_i,
  input wire logic [15:0] trial_i,
  output logic comparator_o
);
  ////////////////////////////////////////////////////////////////////////////
  // held sample and a comparator that is meaningless while tracking
  int held_q;
  logic toggle_q;

  // tracks the input only while connected, so later input changes cannot leak in
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      held_q <= 0;
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
      if (switches_i.inputs_connect) begin
        held_q <= vin_i;
      end
    end
  end

  // toggles while sampling: a stale level here must not look like a decision
  // an int sample lets over- and underrange saturate the comparator
  assign comparator_o = switches_i.inputs_connect ? toggle_q
                        : (held_q >= int'({16'h0000, trial_i}));
endmodule

// >>> tb/tb_sar_conversion_control.sv
`include "sarcc_regs.svh"
module tb_sar_conversion_control
  import sarcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_n = 1'b1;
  logic cs = 1'b1;
  logic pd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rd_data;
  logic busy_o;
  sarcc_sw_t switches_o;
  logic [15:0] dac_trial_o;
  sarcc_result_t result_o;
  logic result_valid_o;
  logic low_power_o;
  logic cmp;
  int vin = 0;
  int err_count = 0;
  int cmp_count = 0;
  int vals[6] = '{0, 32768, 65535, 4660, 70000, -5};

  always #10 clock_i = ~clock_i;

  // short gap limit keeps the stale-result case quick
  sarcc_ctrl #(.GAP_CYCLES(200)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .conversion_start_n_i(start_n),
    .coding_select_i(cs), .power_down_i(pd), .comparator_i(cmp), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rd_data), .busy_o(busy_o), .switches_o(switches_o), .dac_trial_o(dac_trial_o),
    .result_o(result_o), .result_valid_o(result_valid_o), .low_power_o(low_power_o));

  sarcc_afe_model afe (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .vin_i(vin), .switches_i(switches_o),
    .trial_i(dac_trial_o), .comparator_o(cmp));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    @(negedge clock_i);
    chk(rd_data, exp);
  endtask

  function automatic logic [15:0] f_code(input int v);
    logic [15:0] c;
    c = (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : v[15:0];
    return c ^ (cs ? 16'h0000 : 16'h8000);
  endfunction

  // pin low after a few high cycles so the synchroniser sees a clean edge
  task automatic kick();
    int i;
    repeat (3) @(posedge clock_i);
    start_n <= 1'b0;
    for (i = 0; i < 10 && busy_o !== 1'b1; i++) @(negedge clock_i);
  endtask

  // poke 1: extra start edge while busy, poke 2: power down while busy
  task automatic convert(input int v, input int lat, input logic st, input int poke);
    int n;
    logic [15:0] code;
    vin = v;
    kick();
    code = f_code(v);
    chk(busy_o, 1'b1);
    chk(switches_o, 4'b0010);
    @(negedge clock_i);
    chk(switches_o, 4'b0001);
    chk(dac_trial_o, 16'h8000);
    vin = v ^ 32'h2468;
    for (n = 1; n < 200 && result_valid_o !== 1'b1; n++) begin
      @(posedge clock_i);
      if (n == 2) start_n <= 1'b1;
      if (n == 6 && poke == 1) start_n <= 1'b0;
      if (n == 6 && poke == 2) pd <= 1'b1;
      if (n == 10) start_n <= 1'b1;
      @(negedge clock_i);
    end
    chk(n, lat);
    chk(busy_o, 1'b0);
    chk(result_o.code, code);
    chk(result_o.stale, st);
    chk(switches_o, 4'b1110);
    repeat (8) begin
      @(negedge clock_i);
      chk(busy_o, 1'b0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(negedge clock_i);
    chk({busy_o, switches_o, result_valid_o, low_power_o}, 7'b0111000);
    chk(result_o, 17'h0);
    reg_rd(`SARCC_CTRL_OFS, 32'h1);
    reg_wr(4'hc, 32'h3);
    reg_rd(4'hc, 32'h0);
    // reserved mode code must run with normal timing and never flag stale
    reg_wr(`SARCC_CTRL_OFS, 32'h3);
    reg_rd(`SARCC_CTRL_OFS, 32'h3);
    foreach (vals[i]) begin
      for (int c = 1; c >= 0; c--) begin
        @(posedge clock_i);
        cs <= c[0];
        convert(vals[i], 82, 1'b0, 0);
      end
    end
    reg_rd(`SARCC_CODE_OFS, 32'h8000);
    reg_wr(`SARCC_CTRL_OFS, 32'h0);
    convert(1000, 66, 1'b0, 0);
    convert(2000, 66, 1'b0, 1);
    repeat (250) @(posedge clock_i);
    convert(3000, 66, 1'b1, 0);
    reg_rd(`SARCC_STAT_OFS, 32'h4);
    reg_rd(`SARCC_CODE_OFS, {15'h0, 1'b1, f_code(3000)});
    reg_wr(`SARCC_CTRL_OFS, 32'h2);
    convert(40000, 82, 1'b0, 0);
    chk(low_power_o, 1'b1);
    reg_wr(`SARCC_CTRL_OFS, 32'h1);
    convert(50000, 82, 1'b0, 2);
    chk(low_power_o, 1'b1);
    reg_rd(`SARCC_STAT_OFS, 32'h1a);
    kick();
    chk(busy_o, 1'b0);
    @(posedge clock_i);
    pd <= 1'b0;
    start_n <= 1'b1;
    repeat (4) @(posedge clock_i);
    kick();
    chk(busy_o, 1'b1);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    @(posedge clock_i);
    sys_rst_i <= 1'b0;
    start_n <= 1'b1;
    repeat (90) begin
      @(negedge clock_i);
      chk({busy_o, result_valid_o}, 2'b00);
    end
    // first fastest result after reset is flagged even with a short gap
    reg_wr(`SARCC_CTRL_OFS, 32'h0);
    convert(123, 66, 1'b1, 0);
    end_of_test();
  end
endmodule
